//--- dpsl_regs.svh
// Register map, field positions, reset values and bit-rate figures of the dual serial line block
`ifndef DPSL_REGS_SVH
`define DPSL_REGS_SVH
`define DPSL_OFS_CTRL    8'h00
`define DPSL_OFS_CFG1    8'h04
`define DPSL_OFS_CFG2    8'h08
`define DPSL_OFS_TX1     8'h0C
`define DPSL_OFS_TX2     8'h10
`define DPSL_OFS_RX1     8'h14
`define DPSL_OFS_RX2     8'h18
`define DPSL_OFS_STAT    8'h1C
`define DPSL_OFS_MASK    8'h20
`define DPSL_OFS_CHST    8'h24
`define DPSL_CTRL_LINK   0
`define DPSL_CTRL_ALLOW  1
`define DPSL_CTRL_START  2
`define DPSL_CTRL_STN_LO 8
`define DPSL_CFG_D8      0
`define DPSL_CFG_PE      1
`define DPSL_CFG_PODD    2
`define DPSL_CFG_STOP2   3
`define DPSL_CFG_SUM     4
`define DPSL_CFG_WRUN    5
`define DPSL_CFG_RATE_LO 8
`define DPSL_CFG_PROT_LO 12
`define DPSL_CFG_RST     14'h0004
`define DPSL_RATE_AUTO   4'h0
`define DPSL_RATE_MAX1   4'hE
`define DPSL_RATE_MAX2   4'hD
`define DPSL_ST_RX       0
`define DPSL_ST_PERR     1
`define DPSL_ST_FERR     2
`define DPSL_ST_NAK      3
`define DPSL_ST_CFGREF   8
`define DPSL_CLK_HZ      40000000
`define DPSL_BAUD_50     50
`define DPSL_BAUD_300    300
`define DPSL_BAUD_600    600
`define DPSL_BAUD_1200   1200
`define DPSL_BAUD_2400   2400
`define DPSL_BAUD_4800   4800
`define DPSL_BAUD_9600   9600
`define DPSL_BAUD_14400  14400
`define DPSL_BAUD_19200  19200
`define DPSL_BAUD_28800  28800
`define DPSL_BAUD_38400  38400
`define DPSL_BAUD_57600  57600
`define DPSL_BAUD_115200 115200
`define DPSL_BAUD_230400 230400
`endif

//--- dpsl_pkg.sv
// Types shared by the dual serial line block
package dpsl_pkg;
  typedef enum logic [1:0] {
    DPSL_PROTO_TOOL  = 2'h0,
    DPSL_PROTO_CMD   = 2'h1,
    DPSL_PROTO_RAW   = 2'h2,
    DPSL_PROTO_BIDIR = 2'h3
  } dpsl_proto_e;
  typedef enum logic [1:0] {
    DPSL_TX_IDLE = 2'b01,
    DPSL_TX_SEND = 2'b10
  } dpsl_tx_e;
  typedef enum logic [3:0] {
    DPSL_RX_IDLE = 4'b0001,
    DPSL_RX_HALF = 4'b0010,
    DPSL_RX_BITS = 4'b0100,
    DPSL_RX_MEAS = 4'b1000
  } dpsl_rx_e;
  typedef logic [13:0] dpsl_cfg_t;
endpackage : dpsl_pkg

//--- dpsl_top.sv
// Two-channel asynchronous serial line with APB configuration, linked mode and auto rate
`timescale 1ns/10ps
`include "dpsl_regs.svh"

module dpsl_top
  import dpsl_pkg::*;
#(
  parameter int CLK_HZ = `DPSL_CLK_HZ
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic [1:0]  rxd_in,
  output logic      [1:0]  txd_out,
  input  wire logic        cpu_run_in,
  input  wire logic [1:0]  wr_req_in,
  output logic      [1:0]  wr_grant_out,
  output logic      [1:0]  wr_nak_out,
  output logic      [1:0]  sum_check_out,
  output logic             nv_write_ok_out,
  output logic      [4:0]  station_out,
  output logic             irq_out
);

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Cycles per bit for a rate code; code 0 (auto) falls back to 9600
  function automatic logic [19:0] rate_div(input logic [3:0] code);
    int r;
    unique case (code)
      4'h1:    r = `DPSL_BAUD_50;
      4'h2:    r = `DPSL_BAUD_300;
      4'h3:    r = `DPSL_BAUD_600;
      4'h4:    r = `DPSL_BAUD_1200;
      4'h5:    r = `DPSL_BAUD_2400;
      4'h6:    r = `DPSL_BAUD_4800;
      4'h8:    r = `DPSL_BAUD_14400;
      4'h9:    r = `DPSL_BAUD_19200;
      4'hA:    r = `DPSL_BAUD_28800;
      4'hB:    r = `DPSL_BAUD_38400;
      4'hC:    r = `DPSL_BAUD_57600;
      4'hD:    r = `DPSL_BAUD_115200;
      4'hE:    r = `DPSL_BAUD_230400;
      default: r = `DPSL_BAUD_9600;
    endcase
    return 20'(CLK_HZ / r);
  endfunction : rate_div

  // Replace an illegal rate by auto, and a word with reserved bits set by the reset setting, before storing a channel setting
  function automatic dpsl_cfg_t sanitize(input logic ch, input logic [31:0] w);
    dpsl_cfg_t c;
    logic [3:0] lim;
    c = {w[13:12], w[11:8], 2'h0, w[5:0]};
    lim = ch ? `DPSL_RATE_MAX2 : `DPSL_RATE_MAX1;
    if (w[11:8] > lim) begin
      c[11:8] = `DPSL_RATE_AUTO;
    end
    if (w[31:14] != 18'h00000 || w[7:6] != 2'h0) begin
      c = `DPSL_CFG_RST;
    end
    return c;
  endfunction : sanitize

  // Effective rate code: tool link always runs on automatic rate
  function automatic logic [3:0] eff_rate(input dpsl_cfg_t c);
    return (c[13:12] == DPSL_PROTO_TOOL) ? `DPSL_RATE_AUTO : c[11:8];
  endfunction : eff_rate

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  dpsl_cfg_t   cfg [2];
  logic        linked;
  logic        allow_chg;
  logic        started;
  logic [4:0]  station;
  logic [8:0]  stat;
  logic [8:0]  mask;
  logic [7:0]  rx_data [2];
  logic [1:0]  tx_busy;
  logic [1:0]  auto_lock;
  logic [1:0]  run_sync;
  logic [1:0]  rx_done;
  logic [1:0]  rx_perr;
  logic [1:0]  rx_ferr;
  logic [1:0]  nak_ev;

  wire         acc       = psel_in & penable_in;
  wire         setup     = psel_in & ~penable_in;
  wire         wr_acc    = acc & pwrite_in;
  wire         rd_stat   = acc & ~pwrite_in & (paddr_in == `DPSL_OFS_STAT);
  wire         cfg_open  = ~started | allow_chg;
  wire         hit_ctrl  = paddr_in == `DPSL_OFS_CTRL;
  wire         hit_cfg1  = paddr_in == `DPSL_OFS_CFG1;
  wire         hit_cfg2  = paddr_in == `DPSL_OFS_CFG2;
  wire         hit_tx1   = paddr_in == `DPSL_OFS_TX1;
  wire         hit_tx2   = paddr_in == `DPSL_OFS_TX2;
  wire         hit_mask  = paddr_in == `DPSL_OFS_MASK;
  wire         mapped    = (paddr_in[1:0] == 2'h0) && (paddr_in <= `DPSL_OFS_CHST);
  wire         cfg_try   = wr_acc & (hit_ctrl | hit_cfg1 | hit_cfg2);
  wire         cfg_ok    = cfg_try & cfg_open;
  wire [1:0]   sw_tx     = {wr_acc & hit_tx2, wr_acc & hit_tx1};

  assign pready_out      = 1'b1;
  assign pslverr_out     = acc & ~mapped;
  assign nv_write_ok_out = cfg_open;
  assign station_out     = station;
  assign irq_out         = |(stat & mask);

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      linked    <= 1'b0;
      allow_chg <= 1'b0;
      started   <= 1'b0;
      station   <= 5'h00;
      cfg[0]    <= `DPSL_CFG_RST;
      cfg[1]    <= `DPSL_CFG_RST;
      mask      <= 9'h000;
    end else begin
      if (cfg_ok && hit_ctrl) begin
        linked    <= pwdata_in[`DPSL_CTRL_LINK];
        allow_chg <= pwdata_in[`DPSL_CTRL_ALLOW];
        station   <= pwdata_in[`DPSL_CTRL_STN_LO +: 5];
      end
      if (wr_acc && hit_ctrl && pwdata_in[`DPSL_CTRL_START]) begin
        started <= 1'b1;
      end
      if (cfg_ok && hit_cfg1) begin
        cfg[0] <= sanitize(1'b0, pwdata_in);
      end
      if (cfg_ok && hit_cfg2) begin
        cfg[1] <= sanitize(1'b1, pwdata_in);
      end
      if (wr_acc && hit_mask) begin
        mask <= pwdata_in[8:0];
      end
    end
  end

  // Sticky events; a new event in the clearing cycle survives the read
  wire [8:0] ev = {cfg_try & ~cfg_open,
                   nak_ev[1], rx_ferr[1], rx_perr[1], rx_done[1],
                   nak_ev[0], rx_ferr[0], rx_perr[0], rx_done[0]};

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      stat <= 9'h000;
    end else begin
      stat <= (rd_stat ? 9'h000 : stat) | ev;
    end
  end

  // Read data is latched in the setup cycle so it is stable in the access phase
  logic [31:0] rd_mux;
  always_comb begin
    unique case (paddr_in)
      `DPSL_OFS_CTRL: rd_mux = {19'h00000, station, 5'h00, started, allow_chg, linked};
      `DPSL_OFS_CFG1: rd_mux = {18'h00000, cfg[0]};
      `DPSL_OFS_CFG2: rd_mux = {18'h00000, cfg[1]};
      `DPSL_OFS_RX1:  rd_mux = {24'h000000, rx_data[0]};
      `DPSL_OFS_RX2:  rd_mux = {24'h000000, rx_data[1]};
      `DPSL_OFS_STAT: rd_mux = {23'h000000, stat};
      `DPSL_OFS_MASK: rd_mux = {23'h000000, mask};
      `DPSL_OFS_CHST: rd_mux = {28'h0000000, auto_lock, tx_busy};
      default:        rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      prdata_out <= 32'h00000000;
    end else if (setup) begin
      prdata_out <= rd_mux;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Running-controller write gate

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      run_sync <= 2'b00;
    end else begin
      run_sync <= {run_sync[0], cpu_run_in};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Channels

  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    localparam int OTH = 1 - ch;

    wire        d8    = cfg[ch][`DPSL_CFG_D8];
    wire        pe    = cfg[ch][`DPSL_CFG_PE];
    wire        podd  = cfg[ch][`DPSL_CFG_PODD];
    wire        stop2 = cfg[ch][`DPSL_CFG_STOP2];
    wire [1:0]  proto = cfg[ch][13:12];
    wire        autor = eff_rate(cfg[ch]) == `DPSL_RATE_AUTO;
    logic [19:0] auto_div;
    wire [19:0] div   = autor ? auto_div : rate_div(eff_rate(cfg[ch]));
    wire [3:0]  nd    = d8 ? 4'h8 : 4'h7;

    assign sum_check_out[ch] = cfg[ch][`DPSL_CFG_SUM]
                               & ((proto == DPSL_PROTO_CMD) | (proto == DPSL_PROTO_BIDIR));

    // Write request from the protocol layer
    wire refuse = run_sync[1] & ~cfg[ch][`DPSL_CFG_WRUN];
    always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
        wr_grant_out[ch] <= 1'b0;
        nak_ev[ch]       <= 1'b0;
      end else begin
        wr_grant_out[ch] <= wr_req_in[ch] & ~refuse;
        nak_ev[ch]       <= wr_req_in[ch] & refuse;
      end
    end
    assign wr_nak_out[ch] = nak_ev[ch];

    // Transmitter
    dpsl_tx_e    tx_st;
    logic [11:0] tx_sh;
    logic [3:0]  tx_cnt;
    logic [19:0] tx_tim;
    wire  [7:0]  tx_src = linked ? rx_data[OTH] : pwdata_in[7:0];
    wire         tx_go  = linked ? rx_done[OTH] : sw_tx[ch];
    wire  [7:0]  tx_d   = d8 ? tx_src : {1'b0, tx_src[6:0]};
    wire         tx_par = (^tx_d) ^ podd;
    logic [11:0] tx_frm;

    always_comb begin
      tx_frm = 12'hFFF;
      tx_frm[0] = 1'b0;
      for (int i = 0; i < 8; i++) begin
        if (4'(i) < nd) begin
          tx_frm[i + 1] = tx_d[i];
        end
      end
      if (pe) begin
        tx_frm[nd + 4'h1] = tx_par;
      end
    end

    wire [3:0] tx_len = 4'h2 + nd + {3'h0, pe} + {3'h0, stop2};

    always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
        tx_st  <= DPSL_TX_IDLE;
        tx_sh  <= 12'hFFF;
        tx_cnt <= 4'h0;
        tx_tim <= 20'h00000;
      end else begin
        unique case (tx_st)
          DPSL_TX_IDLE: begin
            if (tx_go) begin
              tx_sh  <= tx_frm;
              tx_cnt <= tx_len;
              tx_tim <= div;
              tx_st  <= DPSL_TX_SEND;
            end
          end
          DPSL_TX_SEND: begin
            if (tx_tim == 20'h00001) begin
              tx_tim <= div;
              tx_sh  <= {1'b1, tx_sh[11:1]};
              tx_cnt <= tx_cnt - 4'h1;
              if (tx_cnt == 4'h1) begin
                tx_st <= DPSL_TX_IDLE;
              end
            end else begin
              tx_tim <= tx_tim - 20'h00001;
            end
          end
        endcase
      end
    end
    assign txd_out[ch] = tx_sh[0];
    assign tx_busy[ch] = tx_st == DPSL_TX_SEND;

    // Receiver, sampling at mid-bit
    logic [1:0]  rx_sync;
    logic        rx_prev;
    dpsl_rx_e    rx_st;
    logic [10:0] rx_sh;
    logic [3:0]  rx_idx;
    logic [19:0] rx_tim;
    wire         rx_pin  = rx_sync[1];
    wire         rx_fall = rx_prev & ~rx_pin;
    wire  [3:0]  rx_len  = nd + {3'h0, pe} + 4'h1;
    wire  [7:0]  rx_d    = d8 ? rx_sh[7:0] : {1'b0, rx_sh[6:0]};
    wire         rx_pbad = pe & (((^rx_d) ^ podd) != rx_sh[nd]);
    wire         rx_sbad = ~rx_pin;

    always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
        rx_sync         <= 2'b11;
        rx_prev         <= 1'b1;
        rx_st           <= DPSL_RX_IDLE;
        rx_sh           <= 11'h000;
        rx_idx          <= 4'h0;
        rx_tim          <= 20'h00000;
        rx_data[ch]     <= 8'h00;
        rx_done[ch]     <= 1'b0;
        rx_perr[ch]     <= 1'b0;
        rx_ferr[ch]     <= 1'b0;
        auto_lock[ch]   <= 1'b0;
        auto_div        <= rate_div(`DPSL_RATE_AUTO);
      end else begin
        rx_sync     <= {rx_sync[0], rxd_in[ch]};
        rx_prev     <= rx_pin;
        rx_done[ch] <= 1'b0;
        rx_perr[ch] <= 1'b0;
        rx_ferr[ch] <= 1'b0;
        if (!autor) begin
          auto_lock[ch] <= 1'b0;
        end
        unique case (rx_st)
          DPSL_RX_IDLE: begin
            rx_tim <= {1'b0, div[19:1]};
            rx_idx <= 4'h0;
            if (rx_fall && autor && !auto_lock[ch]) begin
              // The fall is seen one cycle into the start bit
              rx_tim <= 20'h00001;
              rx_st  <= DPSL_RX_MEAS;
            end else if (rx_fall) begin
              rx_st <= DPSL_RX_HALF;
            end
          end
          DPSL_RX_MEAS: begin
            // First start bit sets the rate; that character is consumed
            rx_tim <= rx_tim + 20'h00001;
            if (rx_pin) begin
              auto_div      <= rx_tim + 20'h00001;
              auto_lock[ch] <= 1'b1;
              rx_st         <= DPSL_RX_IDLE;
            end
          end
          DPSL_RX_HALF: begin
            if (rx_tim <= 20'h00001) begin
              rx_tim <= div;
              rx_st  <= rx_pin ? DPSL_RX_IDLE : DPSL_RX_BITS;
            end else begin
              rx_tim <= rx_tim - 20'h00001;
            end
          end
          DPSL_RX_BITS: begin
            if (rx_tim == 20'h00001) begin
              rx_tim <= div;
              if (rx_idx == rx_len - 4'h1) begin
                rx_data[ch] <= rx_d;
                rx_done[ch] <= ~rx_sbad;
                rx_perr[ch] <= ~rx_sbad & rx_pbad;
                rx_ferr[ch] <= rx_sbad;
                rx_st       <= DPSL_RX_IDLE;
              end else begin
                rx_sh[rx_idx] <= rx_pin;
                rx_idx        <= rx_idx + 4'h1;
              end
            end else begin
              rx_tim <= rx_tim - 20'h00001;
            end
          end
          default: rx_st <= DPSL_RX_IDLE;
        endcase
      end
    end
  end

endmodule : dpsl_top

//--- dpsl_top_sva.sv
// Port checker for the dual serial line block
`timescale 1ns/10ps
module dpsl_top_chk #(
  parameter int CLK_HZ = 40000000
) (
  input wire logic       sys_clk_in,
  input wire logic       rst_in,
  input wire logic       psel_in,
  input wire logic       penable_in,
  input wire logic       pwrite_in,
  input wire logic       pready_out,
  input wire logic       pslverr_out,
  input wire logic [1:0] txd_out,
  input wire logic [1:0] wr_req_in,
  input wire logic [1:0] wr_grant_out,
  input wire logic [1:0] wr_nak_out,
  input wire logic [1:0] sum_check_out,
  input wire logic       nv_write_ok_out,
  input wire logic [4:0] station_out,
  input wire logic       irq_out
);
  localparam int MIN_DIV = CLK_HZ / 230400;
  logic [15:0] low_run;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // Length of the current low run on the first channel's line
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || txd_out[0])
      low_run <= 16'h0000;
    else
      low_run <= low_run + 16'h0001;
  end
  property p_ready; psel_in && penable_in |-> pready_out; endproperty
  a_ready: assert property (p_ready) else $error("access without ready");
  property p_err; pslverr_out |-> psel_in && penable_in; endproperty
  a_err: assert property (p_err) else $error("error outside access");
  property p_answer; |wr_req_in |=> (wr_grant_out ^ wr_nak_out) == $past(wr_req_in); endproperty
  a_answer: assert property (p_answer) else $error("write request not answered");
  property p_cause; ((wr_grant_out | wr_nak_out) & ~$past(wr_req_in)) == 2'b00; endproperty
  a_cause: assert property (p_cause) else $error("answer without request");
  property p_excl; (wr_grant_out & wr_nak_out) == 2'b00; endproperty
  a_excl: assert property (p_excl) else $error("grant and refusal together");
  property p_reset;
    disable iff (1'b0) rst_in |=> txd_out == 2'b11 && !irq_out && nv_write_ok_out
      && station_out == 5'h00 && sum_check_out == 2'b00;
  endproperty
  a_reset: assert property (p_reset) else $error("bad reset state");
  property p_cfg; $changed({sum_check_out, station_out, nv_write_ok_out})
    |-> $past(psel_in && penable_in && pwrite_in); endproperty
  a_cfg: assert property (p_cfg) else $error("setting changed without write");
  property p_bit_len; $rose(txd_out[0]) |-> low_run >= MIN_DIV; endproperty
  a_bit_len: assert property (p_bit_len) else $error("bit shorter than fastest rate");
  c_nak: cover property (|wr_nak_out);
  c_grant: cover property (|wr_grant_out);
  c_irq: cover property ($rose(irq_out));
endmodule : dpsl_top_chk

bind dpsl_top dpsl_top_chk #(.CLK_HZ(CLK_HZ)) u_chk (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .pready_out(pready_out), .pslverr_out(pslverr_out), .txd_out(txd_out),
  .wr_req_in(wr_req_in), .wr_grant_out(wr_grant_out), .wr_nak_out(wr_nak_out),
  .sum_check_out(sum_check_out), .nv_write_ok_out(nv_write_ok_out), .station_out(station_out),
  .irq_out(irq_out)
);

//--- dpsl_peer.sv
// Serial device model attached to both channels
`timescale 1ns/10ps
module dpsl_peer (
  input  wire logic       sys_clk_in,
  input  wire logic [1:0] txd_in,
  output logic      [1:0] rxd_out
);
  initial rxd_out = 2'b11;
  // Start bit, then n bits LSB first; the line rests at its idle high level afterwards
  task automatic send(input int ch, input logic [11:0] b, input int n, input int div);
    rxd_out[ch] <= 1'b0;
    repeat (div) @(posedge sys_clk_in);
    for (int i = 0; i < n; i++) begin
      rxd_out[ch] <= b[i];
      repeat (div) @(posedge sys_clk_in);
    end
    rxd_out[ch] <= 1'b1;
  endtask : send
  // Mid-bit sampling of n bits after the start bit
  task automatic grab(input int ch, input int n, input int div, output logic [11:0] b);
    b = '1;
    while (txd_in[ch] !== 1'b0) @(posedge sys_clk_in);
    repeat (div / 2) @(posedge sys_clk_in);
    for (int i = 0; i < n; i++) begin
      repeat (div) @(posedge sys_clk_in);
      b[i] = txd_in[ch];
    end
  endtask : grab
endmodule : dpsl_peer

//--- dual_port_serial_line_config_bench.sv
// Self-checking bench for the dual serial line block
`timescale 1ns/10ps
`include "dpsl_regs.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end

module dual_port_serial_line_config_bench;
  localparam int HZ  = 4000000;
  localparam int DIV = HZ / 115200;
  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  rxd;
  logic [1:0]  txd;
  logic        cpu_run;
  logic [1:0]  wr_req;
  logic [1:0]  grant;
  logic [1:0]  nak;
  logic [1:0]  sumc;
  logic        nvok;
  logic [4:0]  stn;
  logic        irq;
  logic        err;
  logic [31:0] q;
  logic [11:0] got;
  logic [11:0] eb;
  logic [3:0]  fmts [4] = '{4'h0, 4'h7, 4'hB, 4'h6};
  int          failures = 0;
  int          check_count = 0;
  int          n;

  dpsl_top #(.CLK_HZ(HZ)) u_dut (
    .sys_clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .rxd_in(rxd), .txd_out(txd), .cpu_run_in(cpu_run), .wr_req_in(wr_req),
    .wr_grant_out(grant), .wr_nak_out(nak), .sum_check_out(sumc), .nv_write_ok_out(nvok),
    .station_out(stn), .irq_out(irq));
  dpsl_peer u_peer (.sys_clk_in(clk), .txd_in(txd), .rxd_out(rxd));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask : rd
  // Request is sampled at the next edge; the answer pulse stands for the cycle after it
  task automatic req(input logic [1:0] r, input logic [1:0] g, input logic [1:0] k);
    wr_req <= r;
    @(posedge clk);
    wr_req <= 2'b00;
    @(negedge clk);
    `CHK({grant, nak}, {g, k})
    @(posedge clk);
  endtask : req
  // Bits after the start bit: data, optional parity, stop bits; returns their count
  function automatic int frm(input logic [7:0] c, input logic [3:0] f, output logic [11:0] b);
    int k;
    k = f[0] ? 8 : 7;
    b = '1;
    for (int i = 0; i < k; i++) b[i] = c[i];
    if (f[1]) begin
      b[k] = (^(c & {f[0], 7'h7F})) ^ f[2];
      k++;
    end
    return k + 1 + int'(f[3]);
  endfunction : frm
  task automatic frame_test(input logic [3:0] f, input logic [7:0] c);
    apb(1'b1, `DPSL_OFS_CFG1, 32'h2D00 | 32'(f));
    n = frm(c, f, eb);
    fork
      apb(1'b1, `DPSL_OFS_TX1, 32'(c));
      u_peer.grab(0, n, DIV, got);
    join
    `CHK(got, eb)
    u_peer.send(0, eb, n, DIV);
    repeat (4) @(posedge clk);
    `CHK(irq, 1'b0)
    rd(`DPSL_OFS_RX1, 32'(c & {f[0], 7'h7F}));
    rd(`DPSL_OFS_STAT, 32'h1);
  endtask : frame_test
  task automatic wrap_up;
    if (failures == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, wr_req} = '0;
    cpu_run = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK({sumc, nvok, stn}, 8'h20)
    rd(`DPSL_OFS_CFG2, 32'h4);
    apb(1'b0, 8'h28, 32'h0);
    `CHK(err, 1'b1)
    apb(1'b1, `DPSL_OFS_CFG2, 32'h2E01);
    rd(`DPSL_OFS_CFG2, 32'h2001);
    apb(1'b1, `DPSL_OFS_CFG1, 32'h2E01);
    rd(`DPSL_OFS_CFG1, 32'h2E01);
    apb(1'b1, `DPSL_OFS_CFG1, 32'h80000001);
    rd(`DPSL_OFS_CFG1, 32'h4);
    apb(1'b1, `DPSL_OFS_CTRL, 32'h1F00);
    `CHK(stn, 5'h1F)
    for (int i = 0; i < 4; i++) frame_test(fmts[i], 8'hB5);
    apb(1'b1, `DPSL_OFS_MASK, 32'h2);
    u_peer.send(0, eb ^ 12'h080, n, DIV);
    repeat (4) @(posedge clk);
    `CHK(irq, 1'b1)
    apb(1'b0, `DPSL_OFS_STAT, 32'h0);
    `CHK({q[1], irq}, 2'b10)
    // Both channels at 115200 keeps the sum at the 230400 ceiling
    apb(1'b1, `DPSL_OFS_CFG2, 32'h2D07);
    apb(1'b1, `DPSL_OFS_CFG1, 32'h2D07);
    apb(1'b1, `DPSL_OFS_CTRL, 32'h1F01);
    n = frm(8'h3C, 4'h7, eb);
    fork
      u_peer.send(0, eb, n, DIV);
      u_peer.grab(1, n, DIV, got);
    join
    `CHK(got, eb)
    apb(1'b1, `DPSL_OFS_CFG1, 32'h1D31);
    apb(1'b1, `DPSL_OFS_CFG2, 32'h2D11);
    `CHK(sumc, 2'b01)
    req(2'b11, 2'b01, 2'b10);
    cpu_run <= 1'b0;
    repeat (3) @(posedge clk);
    req(2'b11, 2'b11, 2'b00);
    apb(1'b0, `DPSL_OFS_STAT, 32'h0);
    `CHK(q, 32'h81)
    apb(1'b1, `DPSL_OFS_CTRL, 32'h1F04);
    `CHK(nvok, 1'b0)
    apb(1'b1, `DPSL_OFS_CFG1, 32'h2D00);
    rd(`DPSL_OFS_CFG1, 32'h1D31);
    rd(`DPSL_OFS_STAT, 32'h100);
    wrap_up();
  end
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    wrap_up();
  end
endmodule : dual_port_serial_line_config_bench
